// File: arr_pkg.sv
/*
 * Constants shared by the conversion result read-out block.
 * Assumes an APB slave with 32-bit data and one aligned word per register.
 */
// What this block does
// - Each channel's result registers are read-only, word view for 16-bit and high-byte view for 8-bit access, and writes change nothing.
// - The word view returns the 10-bit code in its upper ten bits and zeros in the lower six.
// - The high-byte view returns the eight most significant bits of the code.
// - The code is the input-to-reference ratio times 1024 plus one half, truncated, so it rounds to the nearest level.
// - The word view equals the code times 64, with the six low bits always zero.
package arr_pkg;
    localparam int          CHANNELS     = 12;
    localparam int          CODE_W       = 10;
    localparam int          WORD_W       = 16;
    localparam int          BYTE_W       = 8;
    localparam int          PAD_W        = 6;
    localparam int          CH_W         = 4;
    localparam logic [11:0] WORD_BASE    = 12'h000;
    localparam logic [11:0] BYTE_BASE    = 12'h040;
    localparam logic [11:0] BANK_MASK    = 12'hfc0;
    localparam logic [9:0]  CODE_RESET   = 10'h000;
    localparam logic [31:0] READ_ZERO    = 32'h0000_0000;
endpackage : arr_pkg

// File: arr_store.sv
/*
 * Per-channel result memory with registered read data.
 * Assumes write strobe and channel come from logic on the same clock.
 */
`timescale 1ns/1ns
module arr_store
    import arr_pkg::*;
(
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              arst_n,
    // Load side
    input  wire logic [CHANNELS-1:0] doneStrobe,
    input  wire logic [CODE_W-1:0] loadCode,
    // Read side
    input  wire logic [CH_W-1:0]   readChannel,
    output logic      [CODE_W-1:0] readCode
);
    logic [CODE_W-1:0] codes [CHANNELS];

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_ch
            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                    codes[g] <= CODE_RESET;
                else if (doneStrobe[g])
                    codes[g] <= loadCode;
            end
        end
    endgenerate

    wire logic [CODE_W-1:0] selCode = (int'(readChannel) < CHANNELS) ?
                                      codes[readChannel] : CODE_RESET;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            readCode <= CODE_RESET;
        else
            readCode <= selCode;
    end
endmodule : arr_store

// File: arr_readout.sv
/*
 * APB read-out of per-channel conversion results.
 * Assumes the converter delivers a one-cycle completion strobe per channel together with the
 * rounded approximation code, both on ref_clk.
 */
`timescale 1ns/1ns
module arr_readout
    import arr_pkg::*;
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Converter side
    input  wire logic [CHANNELS-1:0] conversionDone,
    input  wire logic [CODE_W-1:0]   approximationCode
);
    logic [CODE_W-1:0] readCode;
    logic              waitDone;

    function automatic logic hitBank(input logic [11:0] a, input logic [11:0] base);
        hitBank = ((a & BANK_MASK) == base) && (a[1:0] == 2'h0)
                  && (int'(a[5:2]) < CHANNELS);
    endfunction : hitBank

    wire logic [CH_W-1:0] chSel   = paddr[5:2];
    wire logic            isWord  = hitBank(paddr, WORD_BASE);
    wire logic            isByte  = hitBank(paddr, BYTE_BASE);
    wire logic            mapped  = isWord || isByte;
    wire logic            access  = psel && penable;

    // Code is rounded upstream; loaded verbatim
    arr_store u_store (
        .ref_clk     (ref_clk),
        .arst_n      (arst_n),
        .doneStrobe  (conversionDone),
        .loadCode    (approximationCode),
        .readChannel (chSel),
        .readCode    (readCode)
    );

    // Word view is code times 64, byte view the top eight bits
    wire logic [WORD_W-1:0] wordView = {readCode, {PAD_W{1'b0}}};
    wire logic [BYTE_W-1:0] byteView = readCode[CODE_W-1 -: BYTE_W];
    wire logic [31:0] readMux = isWord ? {16'h0000, wordView} :
                                isByte ? {24'h00_0000, byteView} : READ_ZERO;

    // Read data is captured as the access phase opens, so it stands with pready
    wire logic        openAccess = access && !waitDone;
    wire logic [31:0] nextPrdata = (openAccess && !pwrite) ? readMux : READ_ZERO;

    // One wait state lets the store register its read data
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            waitDone <= 1'b0;
        else
            waitDone <= openAccess;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata <= READ_ZERO;
        else
            prdata <= nextPrdata;
    end

    assign pready  = waitDone;
    // Writes are refused with an error and change nothing
    assign pslverr = waitDone && (pwrite || !mapped);

    wire logic unusedWdata = ^pwdata;

    property p_low_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && isWord && !pwrite) |-> (prdata[PAD_W-1:0] == 6'h00 && prdata[31:16] == 16'h0000);
    endproperty
    a_low_zero: assert property (p_low_zero) else $error("word view low bits not zero");

    property p_write_err;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && pwrite) |-> pslverr;
    endproperty
    a_write_err: assert property (p_write_err) else $error("write not refused");

    property p_byte_top;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && isByte && !pwrite)
        |-> (prdata == {24'h00_0000, $past(readCode[CODE_W-1 -: BYTE_W])});
    endproperty
    a_byte_top: assert property (p_byte_top) else $error("byte view wrong");

    property p_word_code;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && isWord && !pwrite) |-> (prdata[15:6] == $past(readCode));
    endproperty
    a_word_code: assert property (p_word_code) else $error("word view code wrong");

    // Each channel's result reaches a word read set up right after its strobe
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++)
        begin : g_load
            localparam logic [11:0] WORD_ADDR = WORD_BASE + 12'(4 * g);

            sequence s_strobe;
                conversionDone[g] && !psel;
            endsequence

            sequence s_word_read;
                (psel && !penable && !pwrite && paddr == WORD_ADDR && !conversionDone[g])
                ##1 (access && !pwrite && paddr == WORD_ADDR);
            endsequence

            property p_load;
                logic [CODE_W-1:0] c;
                @(posedge ref_clk) disable iff (!arst_n)
                (s_strobe, c = approximationCode) ##1 s_word_read
                |=> (pready && readCode == c && prdata[WORD_W-1:PAD_W] == c);
            endproperty
            a_load: assert property (p_load) else $error("result not loaded");
        end
    endgenerate

    property p_ready_one;
        @(posedge ref_clk) disable iff (!arst_n)
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready held");

    // Setup then access, answered after exactly one wait state
    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        access;
    endsequence

    property p_ready_time;
        @(posedge ref_clk) disable iff (!arst_n)
        s_setup ##1 s_access |=> pready;
    endproperty
    a_ready_time: assert property (p_ready_time) else $error("late answer");

    property p_ready_wait;
        @(posedge ref_clk) disable iff (!arst_n)
        s_setup ##1 s_access |-> !pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("answer without wait");

    property p_unmapped;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && !mapped) |-> (pslverr && prdata == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

    property p_ready_cause;
        @(posedge ref_clk) disable iff (!arst_n)
        pready |-> $past(access);
    endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("answer without request");

    property p_idle_ready;
        @(posedge ref_clk) disable iff (!arst_n)
        !access |=> !pready;
    endproperty
    a_idle_ready: assert property (p_idle_ready) else $error("answer while idle");

    property p_quiet;
        @(posedge ref_clk) disable iff (!arst_n)
        !pready |-> (!pslverr && prdata == READ_ZERO);
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus outputs not idle");

    property p_read_ok;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && mapped && !pwrite) |-> !pslverr;
    endproperty
    a_read_ok: assert property (p_read_ok) else $error("valid read refused");

    property p_err_cause;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && pslverr) |-> (pwrite || !mapped);
    endproperty
    a_err_cause: assert property (p_err_cause) else $error("error without cause");

    property p_err_data;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && pslverr) |-> (prdata == READ_ZERO);
    endproperty
    a_err_data: assert property (p_err_data) else $error("data on refused access");

    property p_err_one;
        @(posedge ref_clk) disable iff (!arst_n)
        pslverr |=> !pslverr;
    endproperty
    a_err_one: assert property (p_err_one) else $error("pslverr held");

    property p_write_quiet;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && pwrite) |-> (prdata == READ_ZERO);
    endproperty
    a_write_quiet: assert property (p_write_quiet) else $error("data on write");

    property p_byte_upper;
        @(posedge ref_clk) disable iff (!arst_n)
        (pready && isByte && !pwrite) |-> (prdata[31:BYTE_W] == 24'h00_0000);
    endproperty
    a_byte_upper: assert property (p_byte_upper) else $error("byte view upper bits");

    property p_reset_clear;
        @(posedge ref_clk)
        $rose(arst_n) |-> (readCode == CODE_RESET && prdata == READ_ZERO && !pready);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear");

    property p_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        (conversionDone == '0) ##1 $stable(chSel) |=> $stable(readCode);
    endproperty
    a_hold: assert property (p_hold) else $error("result changed without strobe");
endmodule : arr_readout

// File: arr_conv_model.sv
/* Converter stand-in: rounds a test voltage to a code and pulses done.
   Assumes fire lasts one ref_clk cycle. */
`timescale 1ns/1ns
module arr_conv_model
    import arr_pkg::*;
#(
    parameter int VREF_MV = 3300
)
(
    // Clock and reset
    input  wire logic                ref_clk,
    input  wire logic                arst_n,
    // Bench side
    input  wire logic                fire,
    input  wire logic [CH_W-1:0]     chan,
    input  wire logic [15:0]         vinMv,
    // Block side
    output logic      [CHANNELS-1:0] conversionDone,
    output logic      [CODE_W-1:0]   approximationCode
);
    wire logic [CODE_W-1:0] roundCode = CODE_W'($rtoi(real'(vinMv) / VREF_MV * 1024.0 + 0.5));
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            conversionDone    <= '0;
            approximationCode <= '0;
        end
        else
        begin
            conversionDone    <= fire ? CHANNELS'(1) << chan : '0;
            approximationCode <= fire ? roundCode : ~approximationCode;
        end
    end
endmodule : arr_conv_model

// File: arr_readout_tb.sv
/* Self-checking bench for the result read-out.
   Assumes the partner converter model and APB reads with one wait state. */
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module arr_readout_tb;
    import arr_pkg::*;
    logic                ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
    logic [11:0]         paddr = '0;
    logic [31:0]         pwdata = '0, prdata;
    logic                pready, pslverr;
    logic [CH_W-1:0]     chan = '0;
    logic [15:0]         vin = '0;
    logic [CHANNELS-1:0] done;
    logic [CODE_W-1:0]   code, held [CHANNELS] = '{default: '0};
    logic [32:0]         q [$], m [$], ex, mk;
    int                  mismatches = 0, compares = 0, cyc = 0, seed = 70474, v;
    arr_readout u_arr_readout (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .conversionDone(done), .approximationCode(code));
    arr_conv_model u_arr_conv_model (.ref_clk(ref_clk), .arst_n(arst_n), .fire(fire),
        .chan(chan), .vinMv(vin), .conversionDone(done), .approximationCode(code));
    initial forever #25 ref_clk = ~ref_clk;
    task tally_and_finish;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic apb(input logic w, input logic [11:0] a, input logic [32:0] e, input logic [32:0] k);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= $random(seed);
        q.push_back(e);
        m.push_back(k);
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input int ch);
        apb(1'b0, WORD_BASE + 12'(4 * ch), {17'h0, held[ch], 6'h0}, '1);
        apb(1'b0, BYTE_BASE + 12'(4 * ch), {25'h0, held[ch][9:2]}, '1);
    endtask : rd
    task automatic conv(input int ch, input int mv);
        @(posedge ref_clk);
        fire <= 1'b1;
        chan <= CH_W'(ch);
        vin <= 16'(mv);
        @(posedge ref_clk);
        fire <= 1'b0;
        held[ch] = CODE_W'((mv * 2048 + 3300) / 6600);
    endtask : conv
    always @(posedge ref_clk)
    begin
        cyc++;
        if (pready === 1'b1)
        begin
            mk = m.pop_front();
            ex = q.pop_front();
            `CHK({pslverr, prdata} & mk, ex)
        end
        if (cyc == 4000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'b1;
        // Only ref_clk runs here, so every access is on the main clock
        rd(0);
        rd(11);
        repeat (2)
            for (int ch = 0; ch < CHANNELS; ch++)
            begin
                v = $unsigned($random(seed)) % 3298;
                conv(ch, ch == 0 ? 0 : ch == 11 ? 3297 : v);
                rd(ch);
                rd(0);
            end
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        held = '{default: '0};
        rd(7);
        conv(5, $unsigned($random(seed)) % 3298);
        apb(1'b1, WORD_BASE + 12'h014, 33'h1_0000_0000, 33'h1_0000_0000);
        apb(1'b1, BYTE_BASE + 12'h014, 33'h1_0000_0000, 33'h1_0000_0000);
        rd(5);
        apb(1'b0, WORD_BASE + 12'h030, 33'h1_0000_0000, '1);
        apb(1'b0, 12'h002, 33'h1_0000_0000, '1);
        apb(1'b0, 12'h080, 33'h1_0000_0000, '1);
        tally_and_finish();
    end
endmodule : arr_readout_tb
